// ===== rtl/repeater_cascade_bus_port_regs.svh
`ifndef REPEATER_CASCADE_BUS_PORT_REGS_SVH
`define REPEATER_CASCADE_BUS_PORT_REGS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define BUS_CLK_PERIOD_NS 160
`define BUS_CLK_HALF_CYCLES (`BUS_CLK_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define ARB_SETTLE_NS 120
`define ARB_SETTLE_CYCLES ((`ARB_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// values
// ----------------------------------------
`define IDLE_VECTOR 5'h1f
`define IDENT_RESET 5'h1f
`define IDENT_HI_PAD 3'h0
`define MGMT_STEP_IDLE 2'h0
`define MGMT_STEP_ID_LO 2'h1
`define MGMT_STEP_ID_HI 2'h2
`define MGMT_STEP_PORT 2'h3
`define FIFO_DEPTH 8
`define NUM_PORTS 12

`endif

// ===== rtl/repeater_cascade_bus_port_pkg.sv
`default_nettype none

package repeater_cascade_bus_port_pkg;

	typedef struct packed
	{
		logic err;
		logic valid;
		logic [3:0] data;
	} nibble_word_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ARB = 2'b01,
		ST_HOLD = 2'b10,
		ST_LISTEN = 2'b11
	} bus_state_t;

	typedef struct packed
	{
		logic busClk;
		logic [3:0] data;
		logic errN;
		logic validN;
		logic activityN;
		logic colInN;
		logic [4:0] vector;
		logic mgmtClk;
	} bus_pins_t;

endpackage : repeater_cascade_bus_port_pkg

`default_nettype wire

// ===== rtl/cascade_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module cascade_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 8
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_reg;
	logic [AW:0] rdPtr_reg;

	wire logic ptrMsbDiffer = wrPtr_reg[AW] != rdPtr_reg[AW];
	wire logic ptrLowEqual = wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0];
	wire logic full = ptrMsbDiffer && ptrLowEqual;
	wire logic empty = !ptrMsbDiffer && ptrLowEqual;
	wire logic doWrite = inValid && !full;
	wire logic doRead = outReady && !empty;

	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_reg[AW-1:0]];

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (doWrite)
			mem[wrPtr_reg[AW-1:0]] <= inData;
	end

	// ----------------------------------------
	// pointers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= wrPtr_reg + (AW+1)'(1);
			if (doRead)
				rdPtr_reg <= rdPtr_reg + (AW+1)'(1);
		end
	end

endmodule : cascade_fifo

`default_nettype wire

// ===== rtl/repeater_cascade_bus_port.sv
// What this block does
// - holder drives received nibbles onto shared data
// - data ownership follows vector arbitration only
// - shared error low mirrors phy receive error
// - shared valid is inverted phy receive valid
// - shared bus timed to bus clock rise
// - direction output high only while driving bus
// - pull activity line low on local activity
// - collision input means another chip collided
// - collision out on two or more actives
// - drive own identifier while any port active
// - differing readback while locally active or not all-ones: release direction and lines
// - matching readback: keep driving shared bus
// - identifier on vector while enable asserted
// - report identifier and port on management nibble
// - management valid low exactly while nibble valid
// - management transfers timed to management clock rise
// - management error low on elasticity overrun/underrun
// - capture identifier straps at reset release
// - all-ones vector means idle, never identifier
// - vector enable gates external vector buffers
`timescale 1ns/1ps
`default_nettype none

`include "repeater_cascade_bus_port_regs.svh"

module repeater_cascade_bus_port #(
	parameter int NUM_PORTS = `NUM_PORTS,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_PORTS-1:0] portActive,
	input wire logic [3:0] phyRxData,
	input wire logic phyRxValid,
	input wire logic phyRxError,
	input wire logic [3:0] rxPortNum,
	input wire logic ebOverrun,
	input wire logic ebUnderrun,
	input wire logic [4:0] repeaterIdent,
	output logic phyReady,
	input wire logic [3:0] sharedNibbleDataIn,
	output logic [3:0] sharedNibbleDataOut,
	output logic sharedNibbleDataOeN,
	input wire logic sharedErrorNIn,
	output logic sharedErrorNOut,
	output logic sharedErrorOeN,
	input wire logic sharedFrameValidNIn,
	output logic sharedFrameValidNOut,
	output logic sharedFrameValidOeN,
	input wire logic sharedBusClockIn,
	output logic sharedBusClockOut,
	output logic sharedBusClockOeN,
	output logic transceiverOutDir,
	input wire logic sharedActivityNIn,
	output logic sharedActivityNOut,
	output logic sharedActivityOeN,
	input wire logic collisionInN,
	output logic collisionOutNOut,
	output logic collisionOutOeN,
	input wire logic [4:0] arbitrationVectorIn,
	output logic [4:0] arbitrationVectorOut,
	output logic [4:0] arbitrationVectorOeN,
	output logic vectorDriveEnableNOut,
	output logic vectorDriveEnableOeN,
	input wire logic mgmtClockIn,
	output logic [3:0] mgmtNibbleOut,
	output logic mgmtNibbleOeN,
	output logic mgmtValidNOut,
	output logic mgmtValidOeN,
	output logic mgmtErrorNOut,
	output logic mgmtErrorOeN,
	output logic [3:0] fwdData,
	output logic fwdValid,
	output logic fwdError,
	output logic fwdStrobe,
	output logic collisionSeen,
	output logic busHeld
);
	localparam logic [2:0] BUS_HALF = 3'(`BUS_CLK_HALF_CYCLES);
	localparam logic [2:0] ARB_SETTLE = 3'(`ARB_SETTLE_CYCLES);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	repeater_cascade_bus_port_pkg::bus_pins_t pinRaw;
	repeater_cascade_bus_port_pkg::bus_pins_t sync1_reg;
	repeater_cascade_bus_port_pkg::bus_pins_t sync2_reg;
	repeater_cascade_bus_port_pkg::bus_pins_t sync3_reg;
	repeater_cascade_bus_port_pkg::bus_pins_t filt_reg;
	repeater_cascade_bus_port_pkg::bus_pins_t filt_next;

	assign pinRaw = '{busClk: sharedBusClockIn, data: sharedNibbleDataIn, errN: sharedErrorNIn,
		validN: sharedFrameValidNIn, activityN: sharedActivityNIn, colInN: collisionInN,
		vector: arbitrationVectorIn, mgmtClk: mgmtClockIn};
	wire logic [$bits(pinRaw)-1:0] syncAgree = ~(sync2_reg ^ sync3_reg);
	assign filt_next = (sync2_reg & syncAgree) | (filt_reg & ~syncAgree);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			sync3_reg <= '1;
			filt_reg <= '1;
		end
		else
		begin
			sync1_reg <= pinRaw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg <= filt_next;
		end
	end

	// ----------------------------------------
	// identifier strap capture
	// ----------------------------------------
	logic [4:0] ident_reg;
	logic identValid_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ident_reg <= `IDENT_RESET;
			identValid_reg <= 1'b0;
		end
		else if (!identValid_reg)
		begin
			ident_reg <= repeaterIdent;
			identValid_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// activity and arbitration decode
	// ----------------------------------------
	logic busClkPrev_reg;
	logic mgmtClkPrev_reg;
	repeater_cascade_bus_port_pkg::bus_state_t state_reg;
	repeater_cascade_bus_port_pkg::bus_state_t state_next;

	wire logic identUsable = identValid_reg && (ident_reg != `IDLE_VECTOR);
	wire logic localActive = identUsable && (|portActive);
	wire logic multiLocal = |(portActive & (portActive - NUM_PORTS'(1)));
	wire logic vectorMatch = filt_reg.vector == ident_reg;
	wire logic vectorIdle = filt_reg.vector == `IDLE_VECTOR;
	wire logic otherActive = localActive && !vectorMatch;
	wire logic busClkRise = filt_reg.busClk && !busClkPrev_reg;
	wire logic mgmtClkRise = filt_reg.mgmtClk && !mgmtClkPrev_reg;
	wire logic holding = state_reg == repeater_cascade_bus_port_pkg::ST_HOLD;
	wire logic collisionAssert = multiLocal || otherActive;

	// ----------------------------------------
	// bus ownership state machine
	// ----------------------------------------
	logic [2:0] settleCnt_reg;
	logic fifoOutValid;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			repeater_cascade_bus_port_pkg::ST_IDLE:
			begin
				if (localActive)
					state_next = repeater_cascade_bus_port_pkg::ST_ARB;
				else if (!filt_reg.activityN || !vectorIdle)
					state_next = repeater_cascade_bus_port_pkg::ST_LISTEN;
			end
			repeater_cascade_bus_port_pkg::ST_ARB:
			begin
				if (!localActive)
					state_next = repeater_cascade_bus_port_pkg::ST_IDLE;
				else if (settleCnt_reg == ARB_SETTLE)
					state_next = vectorMatch ? repeater_cascade_bus_port_pkg::ST_HOLD
						: repeater_cascade_bus_port_pkg::ST_LISTEN;
			end
			repeater_cascade_bus_port_pkg::ST_HOLD:
			begin
				if (!vectorMatch && (localActive || !vectorIdle))
					state_next = repeater_cascade_bus_port_pkg::ST_LISTEN;
				else if (!localActive && !fifoOutValid)
					state_next = repeater_cascade_bus_port_pkg::ST_IDLE;
			end
			repeater_cascade_bus_port_pkg::ST_LISTEN:
			begin
				if (filt_reg.activityN && vectorIdle && !localActive)
					state_next = repeater_cascade_bus_port_pkg::ST_IDLE;
			end
			default:
				state_next = repeater_cascade_bus_port_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= repeater_cascade_bus_port_pkg::ST_IDLE;
			settleCnt_reg <= 3'h0;
			busClkPrev_reg <= 1'b1;
			mgmtClkPrev_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			settleCnt_reg <= (state_reg == repeater_cascade_bus_port_pkg::ST_ARB) ? settleCnt_reg + 3'h1 : 3'h0;
			busClkPrev_reg <= filt_reg.busClk;
			mgmtClkPrev_reg <= filt_reg.mgmtClk;
		end
	end

	// ----------------------------------------
	// nibble buffer toward the shared bus
	// ----------------------------------------
	logic busDiv_reg;
	logic [2:0] divCnt_reg;
	repeater_cascade_bus_port_pkg::nibble_word_t fifoIn;
	repeater_cascade_bus_port_pkg::nibble_word_t fifoOut;

	wire logic divTick = holding && (divCnt_reg == BUS_HALF - 3'h1);
	wire logic launchTick = divTick && busDiv_reg;
	wire logic fifoOutReady = launchTick;
	wire logic acceptLocal = localActive && (state_reg == repeater_cascade_bus_port_pkg::ST_ARB || holding);
	assign fifoIn = '{err: phyRxError, valid: phyRxValid, data: phyRxData};

	cascade_fifo #(
		.WIDTH($bits(repeater_cascade_bus_port_pkg::nibble_word_t)),
		.DEPTH(FIFO_DEPTH)
	) nibbleFifo (
		.clk(clk),
		.rst(rst),
		.inData(fifoIn),
		.inValid(acceptLocal && (phyRxValid || phyRxError)),
		.inReady(phyReady),
		.outData(fifoOut),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady)
	);

	// ----------------------------------------
	// shared bus drive
	// ----------------------------------------
	logic [3:0] busData_reg;
	logic busErrN_reg;
	logic busValidN_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			divCnt_reg <= 3'h0;
			busDiv_reg <= 1'b0;
			busData_reg <= 4'h0;
			busErrN_reg <= 1'b1;
			busValidN_reg <= 1'b1;
		end
		else
		begin
			divCnt_reg <= divTick || !holding ? 3'h0 : divCnt_reg + 3'h1;
			busDiv_reg <= holding ? busDiv_reg ^ divTick : 1'b0;
			if (launchTick)
			begin
				busData_reg <= fifoOutValid ? fifoOut.data : 4'h0;
				busErrN_reg <= !(fifoOutValid && fifoOut.err);
				busValidN_reg <= !(fifoOutValid && fifoOut.valid);
			end
			else if (!holding)
			begin
				busErrN_reg <= 1'b1;
				busValidN_reg <= 1'b1;
			end
		end
	end

	assign sharedNibbleDataOut = busData_reg;
	assign sharedErrorNOut = busErrN_reg;
	assign sharedFrameValidNOut = busValidN_reg;
	assign sharedBusClockOut = busDiv_reg;
	assign sharedNibbleDataOeN = !holding;
	assign sharedErrorOeN = !holding;
	assign sharedFrameValidOeN = !holding;
	assign sharedBusClockOeN = !holding;
	assign busHeld = holding;

	// ----------------------------------------
	// direction, activity, vector, collision
	// ----------------------------------------
	logic dir_reg;
	logic vecEnN_reg;
	logic colOut_reg;
	logic colSeen_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dir_reg <= 1'b0;
			vecEnN_reg <= 1'b1;
			colOut_reg <= 1'b0;
			colSeen_reg <= 1'b0;
		end
		else
		begin
			dir_reg <= state_next == repeater_cascade_bus_port_pkg::ST_HOLD;
			vecEnN_reg <= !localActive;
			colOut_reg <= collisionAssert;
			colSeen_reg <= collisionAssert || !filt_reg.colInN;
		end
	end

	assign transceiverOutDir = dir_reg;
	assign sharedActivityNOut = 1'b0;
	assign sharedActivityOeN = !localActive;
	assign arbitrationVectorOut = 5'h00;
	assign arbitrationVectorOeN = vecEnN_reg ? 5'h1f : ident_reg;
	assign vectorDriveEnableNOut = 1'b0;
	assign vectorDriveEnableOeN = vecEnN_reg;
	assign collisionOutNOut = 1'b0;
	assign collisionOutOeN = !colOut_reg;
	assign collisionSeen = colSeen_reg;

	// ----------------------------------------
	// forwarding from the shared bus
	// ----------------------------------------
	logic [3:0] fwdData_reg;
	logic fwdValid_reg;
	logic fwdError_reg;
	logic fwdStrobe_reg;

	wire logic listenSample = !holding && busClkRise;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fwdData_reg <= 4'h0;
			fwdValid_reg <= 1'b0;
			fwdError_reg <= 1'b0;
			fwdStrobe_reg <= 1'b0;
		end
		else
		begin
			fwdStrobe_reg <= listenSample;
			if (listenSample)
			begin
				fwdData_reg <= filt_reg.data;
				fwdValid_reg <= !filt_reg.validN;
				fwdError_reg <= !filt_reg.errN;
			end
		end
	end

	assign fwdData = fwdData_reg;
	assign fwdValid = fwdValid_reg;
	assign fwdError = fwdError_reg;
	assign fwdStrobe = fwdStrobe_reg;

	// ----------------------------------------
	// management report
	// ----------------------------------------
	logic [1:0] mgmtStep_reg;
	logic [3:0] mgmtNibble_reg;
	logic [3:0] portLatch_reg;
	logic reportPending_reg;
	logic ebErr_reg;

	wire logic holdStart = !holding && state_next == repeater_cascade_bus_port_pkg::ST_HOLD;
	wire logic ebEvent = ebOverrun || ebUnderrun;
	wire logic stepAdvance = mgmtClkRise && (reportPending_reg || mgmtStep_reg != `MGMT_STEP_IDLE);
	wire logic [1:0] stepNext = mgmtStep_reg + 2'h1;
	wire logic [3:0] nibbleNext = (stepNext == `MGMT_STEP_ID_LO) ? ident_reg[3:0]
		: (stepNext == `MGMT_STEP_ID_HI) ? {`IDENT_HI_PAD, ident_reg[4]}
		: (stepNext == `MGMT_STEP_PORT) ? portLatch_reg : 4'h0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mgmtStep_reg <= `MGMT_STEP_IDLE;
			mgmtNibble_reg <= 4'h0;
			portLatch_reg <= 4'h0;
			reportPending_reg <= 1'b0;
			ebErr_reg <= 1'b0;
		end
		else
		begin
			if (holdStart)
				portLatch_reg <= rxPortNum;
			reportPending_reg <= holdStart || (reportPending_reg && !stepAdvance);
			ebErr_reg <= ebEvent || (ebErr_reg && !holdStart);
			if (stepAdvance)
			begin
				mgmtStep_reg <= stepNext;
				mgmtNibble_reg <= nibbleNext;
			end
		end
	end

	assign mgmtNibbleOut = mgmtNibble_reg;
	assign mgmtValidNOut = mgmtStep_reg == `MGMT_STEP_IDLE;
	assign mgmtNibbleOeN = 1'b0;
	assign mgmtValidOeN = 1'b0;
	assign mgmtErrorNOut = !ebErr_reg;
	assign mgmtErrorOeN = 1'b0;

endmodule : repeater_cascade_bus_port

`default_nettype wire

// ===== test/repeater_cascade_bus_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module repeater_cascade_bus_port_monitor #(
	parameter int NUM_PORTS = 12
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_PORTS-1:0] portActive,
	input wire logic ebOverrun,
	input wire logic ebUnderrun,
	input wire logic [4:0] repeaterIdent,
	input wire logic [3:0] sharedNibbleDataOut,
	input wire logic sharedNibbleDataOeN,
	input wire logic sharedErrorOeN,
	input wire logic sharedFrameValidNOut,
	input wire logic sharedFrameValidOeN,
	input wire logic sharedBusClockOut,
	input wire logic sharedBusClockOeN,
	input wire logic transceiverOutDir,
	input wire logic sharedActivityOeN,
	input wire logic collisionOutOeN,
	input wire logic [4:0] arbitrationVectorOeN,
	input wire logic vectorDriveEnableOeN,
	input wire logic mgmtValidNOut,
	input wire logic mgmtErrorNOut,
	input wire logic busHeld
);
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_activity_pull:
	assert property (sharedActivityOeN == !(|portActive && repeaterIdent != 5'h1f)) else $error("activity pull wrong");
	chk_enable_on:
	assert property (|portActive && repeaterIdent != 5'h1f |=> !vectorDriveEnableOeN) else $error("vector enable late");
	chk_enable_off:
	assert property (!(|$past(portActive)) |-> vectorDriveEnableOeN) else $error("vector enable stuck");
	chk_vector_ident:
	assert property (!vectorDriveEnableOeN |-> arbitrationVectorOeN == repeaterIdent) else $error("vector wrong");
	chk_vector_idle:
	assert property (vectorDriveEnableOeN |-> arbitrationVectorOeN == 5'h1f) else $error("vector not released");
	chk_two_ports:
	assert property ($countones(portActive) > 1 |=> !collisionOutOeN) else $error("collision missed");
	chk_mgmt_err:
	assert property (ebOverrun || ebUnderrun |=> !mgmtErrorNOut) else $error("mgmt error missed");
	chk_launch_stable:
	assert property (!sharedBusClockOeN && $rose(sharedBusClockOut) |-> $stable(sharedNibbleDataOut)
		&& $stable(sharedFrameValidNOut)) else $error("data moved at clock rise");
	chk_released_lines:
	assert property (!busHeld |-> sharedNibbleDataOeN && sharedFrameValidOeN && !transceiverOutDir)
		else $error("lines driven without bus");
	chk_holder_drives:
	assert property (busHeld |-> transceiverOutDir && !sharedErrorOeN && !sharedBusClockOeN)
		else $error("holder not driving");
	cov_hold: cover property ($rose(busHeld));
	cov_collide: cover property ($fell(collisionOutOeN));
	cov_report: cover property ($fell(mgmtValidNOut));
endmodule : repeater_cascade_bus_port_monitor

bind repeater_cascade_bus_port repeater_cascade_bus_port_monitor #(.NUM_PORTS(NUM_PORTS)) mon (.clk, .rst,
	.portActive, .ebOverrun, .ebUnderrun, .repeaterIdent, .sharedNibbleDataOut, .sharedNibbleDataOeN,
	.sharedErrorOeN, .sharedFrameValidNOut, .sharedFrameValidOeN, .sharedBusClockOut, .sharedBusClockOeN,
	.transceiverOutDir, .sharedActivityOeN, .collisionOutOeN, .arbitrationVectorOeN, .vectorDriveEnableOeN,
	.mgmtValidNOut, .mgmtErrorNOut, .busHeld);

`default_nettype wire

// ===== test/peer_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module peer_bus_model (
	input wire logic peerOn,
	input wire logic [4:0] peerIdent,
	input wire logic [4:0] vectorWire,
	input wire logic mgmtRun,
	input wire logic colReq,
	output logic [4:0] vecPullN,
	output logic actPullN,
	output logic colN,
	output logic drive,
	output logic busClk,
	output logic [3:0] data,
	output logic validN,
	output logic mgmtClk
);
	// ----
	// peer repeater and statistics chip
	// ----
	logic wins;
	assign vecPullN = peerOn ? peerIdent : 5'h1f;
	assign actPullN = !peerOn;
	assign wins = peerOn && vectorWire == peerIdent;
	assign colN = !(colReq || (peerOn && !wins));
	initial
	begin
		busClk = 1'b0;
		data = 4'h0;
		validN = 1'b1;
		drive = 1'b0;
		mgmtClk = 1'b0;
	end
	always
	begin
		#80;
		drive = wins;
		validN = !wins;
		busClk = wins ? !busClk : 1'b0;
		if (wins && !busClk)
			data = data + 4'h1;
	end
	always
	begin
		#80;
		mgmtClk = mgmtRun ? !mgmtClk : 1'b0;
	end
endmodule : peer_bus_model

`default_nettype wire

// ===== test/tb_repeater_cascade_bus_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_repeater_cascade_bus_port;
	localparam logic [4:0] ID = 5'h1a;
	localparam logic [3:0] MT [3] = '{ID[3:0], {3'h0, ID[4]}, 4'h5};
	logic clk, rst, phyRxValid, phyRxError, ebOverrun, ebUnderrun, peerOn, mgmtRun, colReq;
	logic [11:0] portActive;
	logic [3:0] phyRxData, rxPortNum, sharedNibbleDataOut, mgmtNibbleOut, fwdData, pData;
	logic [4:0] repeaterIdent, peerIdent, arbitrationVectorOut, arbitrationVectorOeN, pVec;
	logic phyReady, sharedNibbleDataOeN, sharedErrorNOut, sharedErrorOeN, sharedFrameValidNOut;
	logic sharedFrameValidOeN, sharedBusClockOut, sharedBusClockOeN, transceiverOutDir, sharedActivityNOut;
	logic sharedActivityOeN, collisionOutNOut, collisionOutOeN, vectorDriveEnableNOut, vectorDriveEnableOeN;
	logic mgmtNibbleOeN, mgmtValidNOut, mgmtValidOeN, mgmtErrorNOut, mgmtErrorOeN, fwdValid, fwdError;
	logic fwdStrobe, collisionSeen, busHeld, pAct, pCol, pDrive, pClk, pValidN, mgmtClockIn;
	int mismatches, num_checks;
	wire logic [4:0] arbitrationVectorIn = arbitrationVectorOeN & pVec;
	wire logic [3:0] sharedNibbleDataIn = !sharedNibbleDataOeN ? sharedNibbleDataOut : pDrive ? pData : 4'hf;
	wire logic sharedErrorNIn = !sharedErrorOeN ? sharedErrorNOut : pDrive ? 1'b1 : 1'b0;
	wire logic sharedFrameValidNIn = !sharedFrameValidOeN ? sharedFrameValidNOut : pDrive ? pValidN : 1'b1;
	wire logic sharedBusClockIn = !sharedBusClockOeN ? sharedBusClockOut : pDrive ? pClk : 1'b1;
	wire logic sharedActivityNIn = sharedActivityOeN & pAct;
	wire logic collisionInN = pCol;

	repeater_cascade_bus_port uut (.clk, .rst, .portActive, .phyRxData, .phyRxValid, .phyRxError,
		.rxPortNum, .ebOverrun, .ebUnderrun, .repeaterIdent, .phyReady, .sharedNibbleDataIn, .sharedNibbleDataOut,
		.sharedNibbleDataOeN, .sharedErrorNIn, .sharedErrorNOut, .sharedErrorOeN, .sharedFrameValidNIn,
		.sharedFrameValidNOut, .sharedFrameValidOeN, .sharedBusClockIn, .sharedBusClockOut, .sharedBusClockOeN,
		.transceiverOutDir, .sharedActivityNIn, .sharedActivityNOut, .sharedActivityOeN, .collisionInN,
		.collisionOutNOut, .collisionOutOeN, .arbitrationVectorIn, .arbitrationVectorOut, .arbitrationVectorOeN,
		.vectorDriveEnableNOut, .vectorDriveEnableOeN, .mgmtClockIn, .mgmtNibbleOut, .mgmtNibbleOeN,
		.mgmtValidNOut, .mgmtValidOeN, .mgmtErrorNOut, .mgmtErrorOeN, .fwdData, .fwdValid, .fwdError,
		.fwdStrobe, .collisionSeen, .busHeld);
	peer_bus_model peer (.peerOn, .peerIdent, .vectorWire(arbitrationVectorIn), .mgmtRun, .colReq,
		.vecPullN(pVec), .actPullN(pAct), .colN(pCol), .drive(pDrive), .busClk(pClk), .data(pData),
		.validN(pValidN), .mgmtClk(mgmtClockIn));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----
	// helpers
	// ----
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk

	function automatic logic pick(input int sel);
		case (sel)
			0: return sharedBusClockIn;
			1: return mgmtClockIn;
			2: return fwdStrobe;
			3: return busHeld;
			default: return collisionSeen;
		endcase
	endfunction : pick

	task automatic await(input int sel, input logic v);
		int n;
		for (n = 0; n < 400 && pick(sel) !== v; n++)
			@(negedge clk);
		if (pick(sel) !== v)
		begin
			chk(1'b0, "wait ran out");
			wrap_up();
		end
	endtask : await

	task automatic rise(input int sel);
		logic last;
		int n;
		last = pick(sel);
		for (n = 0; n < 40; n++)
		begin
			@(negedge clk);
			if (last === 1'b0 && pick(sel) === 1'b1)
				return;
			last = pick(sel);
		end
		chk(1'b0, "edge never came");
		wrap_up();
	endtask : rise

	task settle;
		portActive = 12'h000;
		peerOn = 1'b0;
		colReq = 1'b0;
		repeat (20) @(negedge clk);
	endtask : settle

	// ----
	// scenarios
	// ----
	task t_reset;
		chk(vectorDriveEnableOeN === 1'b1 && arbitrationVectorOeN === 5'h1f, "vector at idle");
		chk(transceiverOutDir === 1'b0 && sharedNibbleDataOeN === 1'b1, "bus at idle");
		chk(mgmtValidNOut === 1'b1 && phyReady === 1'b1, "idle outputs");
		chk(sharedActivityNOut === 1'b0 && collisionOutNOut === 1'b0 && arbitrationVectorOut === 5'h00
			&& vectorDriveEnableNOut === 1'b0, "open drain levels");
		chk(mgmtNibbleOeN === 1'b0 && mgmtValidOeN === 1'b0 && mgmtErrorOeN === 1'b0, "mgmt pins off");
		ebOverrun = 1'b1;
		@(negedge clk);
		ebOverrun = 1'b0;
		@(negedge clk);
		chk(mgmtErrorNOut === 1'b0, "overrun not flagged");
	endtask : t_reset

	task t_hold;
		logic [4:0] q[$];
		logic [4:0] e;
		logic full;
		int i;
		full = 1'b0;
		portActive = 12'h001;
		rxPortNum = 4'h5;
		@(negedge clk);
		@(negedge clk);
		chk(vectorDriveEnableOeN === 1'b0 && arbitrationVectorOeN === ID, "ident not on vector");
		chk(sharedActivityOeN === 1'b0, "activity not pulled");
		phyRxValid = 1'b1;
		for (i = 0; i < 12 && !full; i++)
		begin
			phyRxData = i[3:0];
			phyRxError = (i == 3);
			full = !phyReady;
			if (phyReady === 1'b1)
				q.push_back({phyRxError, phyRxData});
			@(negedge clk);
		end
		phyRxValid = 1'b0;
		phyRxError = 1'b0;
		chk(full && q.size() == 8, "buffer never refused");
		await(3, 1'b1);
		chk(transceiverOutDir === 1'b1 && sharedNibbleDataOeN === 1'b0, "holder not driving");
		for (i = 0; i < 4 && sharedFrameValidNOut !== 1'b0; i++)
			rise(0);
		while (q.size() > 0)
		begin
			e = q.pop_front();
			chk(sharedNibbleDataOut === e[3:0] && sharedFrameValidNOut === 1'b0, "data wrong");
			chk(sharedErrorNOut === !e[4], "error line wrong");
			rise(0);
		end
		chk(sharedFrameValidNOut === 1'b1, "valid after drain");
		mgmtRun = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			rise(1);
			repeat (6) @(negedge clk);
			chk(mgmtValidNOut === (i == 3) && (i == 3 || mgmtNibbleOut === MT[i]), "report wrong");
		end
		mgmtRun = 1'b0;
		portActive = 12'h000;
		await(3, 1'b0);
		chk(transceiverOutDir === 1'b0 && sharedBusClockOeN === 1'b1, "bus kept");
		settle();
	endtask : t_hold

	task t_lose;
		logic [3:0] e;
		peerIdent = 5'h02;
		peerOn = 1'b1;
		repeat (4) @(negedge clk);
		portActive = 12'h010;
		repeat (14) @(negedge clk);
		chk(busHeld === 1'b0 && transceiverOutDir === 1'b0, "loser took bus");
		chk(sharedNibbleDataOeN === 1'b1 && sharedBusClockOeN === 1'b1, "loser drives lines");
		chk(collisionOutOeN === 1'b0, "other chip not flagged");
		rise(0);
		e = sharedNibbleDataIn;
		rise(2);
		chk(fwdData === e && fwdValid === 1'b1 && fwdError === 1'b0, "forward wrong");
		settle();
	endtask : t_lose

	task t_collide;
		colReq = 1'b1;
		await(4, 1'b1);
		colReq = 1'b0;
		portActive = 12'h003;
		@(negedge clk);
		@(negedge clk);
		chk(collisionOutOeN === 1'b0, "two ports not flagged");
		ebUnderrun = 1'b1;
		@(negedge clk);
		ebUnderrun = 1'b0;
		@(negedge clk);
		chk(mgmtErrorNOut === 1'b0, "underrun not flagged");
		settle();
	endtask : t_collide

	task t_no_ident;
		rst = 1'b1;
		repeaterIdent = 5'h1f;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		@(negedge clk);
		portActive = 12'h001;
		repeat (12) @(negedge clk);
		chk(vectorDriveEnableOeN === 1'b1 && sharedActivityOeN === 1'b1 && busHeld === 1'b0, "idle ident used");
		rst = 1'b1;
		repeaterIdent = ID;
		portActive = 12'h000;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
	endtask : t_no_ident

	initial
	begin
		rst = 1'b1;
		portActive = 12'h000;
		phyRxData = 4'h0;
		phyRxValid = 1'b0;
		phyRxError = 1'b0;
		rxPortNum = 4'h0;
		ebOverrun = 1'b0;
		ebUnderrun = 1'b0;
		repeaterIdent = ID;
		peerOn = 1'b0;
		peerIdent = 5'h02;
		mgmtRun = 1'b0;
		colReq = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		@(negedge clk);
		t_reset();
		t_hold();
		t_lose();
		t_collide();
		t_no_ident();
		wrap_up();
	end
endmodule : tb_repeater_cascade_bus_port

`default_nettype wire
